/* File: hdl/ccp_bridge.sv */
// Purpose: apb to crate dataway bridge with lam interrupt logic
// Assumes: dataway and host bus pins are asynchronous to pclk
// Notes: exec accesses stretch the apb access until the cycle ends
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - data moves as 16-bit words; wider values need two transfers
// - upper write/read lines 17-24 are never driven
// - request lines are either driven active or released
// - three programmed registers: control/status, data, command
// - execute runs one cycle classed by command bits 3 and 4
// - same class sets data register and driver direction
// - write loads data and command in either order; second load runs
// - with one register constant a further write needs one transfer
// - read latches read lines at s1 and returns them same transfer
// - data register unchanged by control cycles
// - z or c cycle clears command and data registers
// - status reports q and x of the previous cycle
// - data, command registers read back as written; control keeps bits 0-4 only
// - demand goes on the request line chosen by control level bits
// - chain passed on unless pending demand at matching level
// - matching crate blocks chain, returns acknowledge and data-to-cpu
// - static vector of crate code and lam code on data 0-7
// - 16-bit mask enables lams; masked request stays at source
// - lam status shows every request line, masked or not
// - or of enabled demands through crate mask, 3-bit selector to 4 lines
// - 16-input priority encoder gives 4-bit code, frozen at acknowledge
// - frozen code decoded one-hot clears mask bit, then released
// - master clear resets all but mask, then runs a z cycle
module ccp_bridge #(
	parameter int PHASE_CYC = ccp_pkg::PHASE_CYC,
	parameter logic [3:0] CRATE_CODE = 4'h1 // arbitrary value
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic master_clear,
	input wire logic search_chain_in,
	input wire logic [2:0] iob_level,
	output logic search_chain_out,
	output logic iob_connect,
	output logic iob_data_to_cpu,
	output logic [7:0] iob_data_o,
	output logic iob_data_oe,
	output logic [3:0] iob_irq_o,
	output logic [3:0] iob_irq_oe,
	output logic [4:0] dw_n,
	output logic [3:0] dw_a,
	output logic [4:0] dw_f,
	output logic [15:0] dw_w,
	output logic dw_w_oe,
	input wire logic [15:0] dw_r,
	input wire logic dw_q,
	input wire logic dw_x,
	output logic dw_busy,
	output logic dw_s1,
	output logic dw_s2,
	output logic dw_z,
	output logic dw_c,
	output logic dw_i,
	input wire logic dw_z_sense,
	input wire logic dw_c_sense,
	input wire logic dw_i_sense,
	input wire logic [15:0] graded_lam
);
	// one phase is too short for the synchronisers to settle before the latch
	if (PHASE_CYC < 2 || PHASE_CYC > 15) begin : g_chk
		$error("phase count must be 2 to 15");
	end

	function automatic ccp_pkg::ccp_cls_t cls(input logic [15:0] c);
		if (c[ccp_pkg::F8_BIT])
			return ccp_pkg::CL_CTRL;
		else if (c[ccp_pkg::F16_BIT])
			return ccp_pkg::CL_WRITE;
		else
			return ccp_pkg::CL_READ;
	endfunction

	function automatic logic [3:0] prio(input logic [15:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (v[i])
				r = 4'(i);
		end
		return r;
	endfunction

	function automatic logic [15:0] onehot(input logic [3:0] c);
		return 16'h0001 << c;
	endfunction

	// three-stage input synchronisers, change accepted when 2 and 3 agree
	logic [ccp_pkg::SY_W-1:0] sy1_q, sy2_q, sy3_q, syv_q;
	logic [15:0] s_lam, s_rd;
	logic s_q, s_x, s_zs, s_cs, s_is, s_chain, s_mclr;
	logic [2:0] s_lvl;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sy1_q <= '0;
			sy2_q <= '0;
			sy3_q <= '0;
			syv_q <= '0;
		end else begin
			sy1_q <= {graded_lam, dw_r, dw_q, dw_x, dw_z_sense, dw_c_sense,
				dw_i_sense, search_chain_in, master_clear, iob_level};
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
			syv_q <= (sy3_q & ~(sy2_q ^ sy3_q)) | (syv_q & (sy2_q ^ sy3_q));
		end
	end
	assign {s_lam, s_rd, s_q, s_x, s_zs, s_cs, s_is, s_chain, s_mclr, s_lvl} = syv_q;

	logic mclr_d_q;
	logic mclr_p;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mclr_d_q <= 1'b0;
		else
			mclr_d_q <= s_mclr;
	end
	assign mclr_p = s_mclr & ~mclr_d_q;

	// registers
	logic [15:0] ctrl_q, cmd_q, data_q, mask_q, held_q;
	logic st_q_q, st_x_q, st_z_q, st_c_q;
	logic pready_q, pslverr_q, xrun_q, done_q;
	logic [31:0] prdata_q;
	logic [3:0] cnt_q, held_code_q;
	logic pend_z_q, pend_c_q;
	ccp_pkg::ccp_dw_t dw_st_q;
	ccp_pkg::ccp_ak_t ak_q;
	ccp_pkg::ccp_kind_t kind_q;
	ccp_pkg::ccp_cls_t cyc_cls_q;

	logic acc, wr_fire, is_x, x_start, zc_start, known;
	assign acc = psel && penable && !pready_q;
	assign wr_fire = psel && penable && pready_q && pwrite;
	assign is_x = acc && (paddr == ccp_pkg::A_XCMD ||
		(paddr == ccp_pkg::A_XDAT && pwrite));
	assign zc_start = (dw_st_q == ccp_pkg::DW_IDLE) && (pend_z_q || pend_c_q);
	assign x_start = is_x && !xrun_q && !zc_start &&
		(dw_st_q == ccp_pkg::DW_IDLE) && !mclr_p;
	assign known = paddr[1:0] == 2'b00 && paddr <= ccp_pkg::A_LAM;

	// exec command loaded with the access so the cycle sees it
	logic [15:0] cmd_use, data_use;
	assign cmd_use = (paddr == ccp_pkg::A_XCMD && pwrite) ? pwdata[15:0] : cmd_q;
	assign data_use = (paddr == ccp_pkg::A_XDAT) ? pwdata[15:0] : data_q;

	// apb answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			xrun_q <= 1'b0;
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			if (x_start)
				xrun_q <= 1'b1;
			if (acc && is_x) begin
				if (xrun_q && done_q) begin
					pready_q <= 1'b1;
					xrun_q <= 1'b0;
				end
			end else if (acc) begin
				pready_q <= 1'b1;
				pslverr_q <= !known;
			end
		end
	end

	// read data; exec read returns the word latched at s1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_q <= '0;
		else if (acc) begin
			if (paddr == ccp_pkg::A_CTRL)
				prdata_q <= {16'h0000, ctrl_q};
			else if (paddr == ccp_pkg::A_STAT) begin
				prdata_q <= '0;
				prdata_q[ccp_pkg::ST_I] <= s_is;
				prdata_q[ccp_pkg::ST_Q] <= st_q_q;
				prdata_q[ccp_pkg::ST_X] <= st_x_q;
				prdata_q[ccp_pkg::ST_DEM] <= |(s_lam & mask_q);
				prdata_q[ccp_pkg::ST_C] <= st_c_q;
				prdata_q[ccp_pkg::ST_Z] <= st_z_q;
			end else if (paddr == ccp_pkg::A_DATA || paddr == ccp_pkg::A_XDAT)
				prdata_q <= {16'h0000, data_q};
			else if (paddr == ccp_pkg::A_CMD)
				prdata_q <= {16'h0000, cmd_q};
			else if (paddr == ccp_pkg::A_XCMD)
				prdata_q <= {16'h0000, data_q};
			else if (paddr == ccp_pkg::A_MASK)
				prdata_q <= {16'h0000, mask_q};
			else if (paddr == ccp_pkg::A_LAM)
				prdata_q <= {16'h0000, s_lam};
			else
				prdata_q <= '0;
		end
	end

	// control register; z/c request bits are pulses, not stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_q <= ccp_pkg::CTRL_RST;
		else if (mclr_p)
			ctrl_q <= ccp_pkg::CTRL_RST;
		else begin
			if (wr_fire && paddr == ccp_pkg::A_CTRL)
				ctrl_q <= pwdata[15:0] & ccp_pkg::CT_KEEP;
			// z forces inhibit on until software clears it
			if (dw_st_q == ccp_pkg::DW_SETUP && kind_q == ccp_pkg::KD_Z)
				ctrl_q[ccp_pkg::CT_INH] <= 1'b1;
		end
	end

	// pending unaddressed cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_z_q <= 1'b0;
			pend_c_q <= 1'b0;
		end else if (mclr_p) begin
			pend_z_q <= 1'b1;
			pend_c_q <= 1'b0;
		end else begin
			if (zc_start) begin
				pend_z_q <= 1'b0;
				pend_c_q <= pend_z_q & pend_c_q;
			end
			if (wr_fire && paddr == ccp_pkg::A_CTRL) begin
				if (pwdata[ccp_pkg::CT_GZ])
					pend_z_q <= 1'b1;
				if (pwdata[ccp_pkg::CT_GC])
					pend_c_q <= 1'b1;
			end
		end
	end

	localparam logic [15:0] ZERO = ccp_pkg::ZERO16;
	// command register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cmd_q <= ZERO;
		else if (mclr_p)
			cmd_q <= ZERO;
		else if (dw_st_q == ccp_pkg::DW_GAP && kind_q != ccp_pkg::KD_ADDR)
			cmd_q <= ZERO;
		else if (x_start)
			cmd_q <= cmd_use;
		else if (wr_fire && paddr == ccp_pkg::A_CMD)
			cmd_q <= pwdata[15:0];
	end

	// data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			data_q <= ZERO;
		else if (mclr_p)
			data_q <= ZERO;
		else if (dw_st_q == ccp_pkg::DW_GAP) begin
			if (kind_q != ccp_pkg::KD_ADDR)
				data_q <= ZERO;
			else if (cyc_cls_q == ccp_pkg::CL_READ)
				data_q <= s_rd;
			// control cycles leave the word alone
		end else if (x_start)
			data_q <= data_use;
		else if (wr_fire && paddr == ccp_pkg::A_DATA)
			data_q <= pwdata[15:0];
	end

	// dataway cycle sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dw_st_q <= ccp_pkg::DW_IDLE;
			kind_q <= ccp_pkg::KD_ADDR;
			cyc_cls_q <= ccp_pkg::CL_READ;
			cnt_q <= 4'h0;
			done_q <= 1'b0;
			dw_busy <= 1'b0;
			dw_s1 <= 1'b0;
			dw_s2 <= 1'b0;
			dw_z <= 1'b0;
			dw_c <= 1'b0;
			dw_n <= 5'h00;
			dw_a <= 4'h0;
			dw_f <= 5'h00;
			dw_w <= 16'h0000;
			dw_w_oe <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (dw_st_q)
				ccp_pkg::DW_IDLE: begin
					if (zc_start) begin
						kind_q <= pend_z_q ? ccp_pkg::KD_Z : ccp_pkg::KD_C;
						cyc_cls_q <= ccp_pkg::CL_CTRL;
						dw_z <= pend_z_q;
						dw_c <= 1'b1;
						dw_busy <= 1'b1;
						dw_n <= 5'h00;
						dw_a <= 4'h0;
						dw_f <= 5'h00;
						cnt_q <= 4'(PHASE_CYC);
						dw_st_q <= ccp_pkg::DW_SETUP;
					end else if (x_start) begin
						kind_q <= ccp_pkg::KD_ADDR;
						cyc_cls_q <= cls(cmd_use);
						dw_busy <= 1'b1;
						dw_n <= cmd_use[ccp_pkg::N_LO +: 5];
						dw_a <= cmd_use[ccp_pkg::A_LO +: 4];
						dw_f <= cmd_use[ccp_pkg::F_LO +: 5];
						// only 16 write lines exist; 17-24 left to pull-ups
						dw_w <= data_use;
						dw_w_oe <= cls(cmd_use) == ccp_pkg::CL_WRITE;
						cnt_q <= 4'(PHASE_CYC);
						dw_st_q <= ccp_pkg::DW_SETUP;
					end
				end
				ccp_pkg::DW_SETUP: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h1) begin
						cnt_q <= 4'(PHASE_CYC);
						dw_s1 <= 1'b1;
						dw_st_q <= ccp_pkg::DW_S1;
					end
				end
				ccp_pkg::DW_S1: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h1) begin
						cnt_q <= 4'(PHASE_CYC);
						dw_s1 <= 1'b0;
						dw_st_q <= ccp_pkg::DW_GAP;
					end
				end
				ccp_pkg::DW_GAP: begin
					cnt_q <= 4'(PHASE_CYC);
					dw_s2 <= 1'b1;
					dw_st_q <= ccp_pkg::DW_S2;
				end
				ccp_pkg::DW_S2: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h1) begin
						dw_s2 <= 1'b0;
						dw_busy <= 1'b0;
						dw_z <= 1'b0;
						dw_c <= 1'b0;
						dw_w_oe <= 1'b0;
						done_q <= 1'b1;
						dw_st_q <= ccp_pkg::DW_DONE;
					end
				end
				default: dw_st_q <= ccp_pkg::DW_IDLE;
			endcase
		end
	end

	// status taken in the gap: synchronised lines then show what stood at s1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q_q <= 1'b0;
			st_x_q <= 1'b0;
			st_z_q <= 1'b0;
			st_c_q <= 1'b0;
		end else if (mclr_p) begin
			st_q_q <= 1'b0;
			st_x_q <= 1'b0;
			st_z_q <= 1'b0;
			st_c_q <= 1'b0;
		end else if (dw_st_q == ccp_pkg::DW_GAP) begin
			st_q_q <= s_q;
			st_x_q <= s_x;
			if (kind_q == ccp_pkg::KD_Z)
				st_z_q <= s_zs;
			if (kind_q != ccp_pkg::KD_ADDR)
				st_c_q <= s_cs;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dw_i <= 1'b0;
		else
			dw_i <= ctrl_q[ccp_pkg::CT_INH];
	end

	// lam demand and request lines
	logic [15:0] en_lam;
	logic cdem, match;
	assign en_lam = s_lam & mask_q;
	assign cdem = |en_lam && ctrl_q[ccp_pkg::CT_CDM];
	assign match = cdem && s_lvl == ctrl_q[ccp_pkg::CT_LVL_LO +: 3];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			iob_irq_o <= 4'h0;
			iob_irq_oe <= 4'h0;
		end else begin
			// drive high or let go, so crates wire-or
			iob_irq_o <= 4'hf;
			for (int i = 0; i < 4; i++) begin
				iob_irq_oe[i] <= cdem &&
					ctrl_q[ccp_pkg::CT_LVL_LO +: 3] == 3'(i);
			end
		end
	end

	// identification search
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ak_q <= ccp_pkg::AK_IDLE;
			search_chain_out <= 1'b0;
			iob_connect <= 1'b0;
			iob_data_to_cpu <= 1'b0;
			iob_data_o <= 8'h00;
			iob_data_oe <= 1'b0;
			held_q <= 16'h0000;
			held_code_q <= 4'h0;
		end else if (mclr_p) begin
			ak_q <= ccp_pkg::AK_IDLE;
			search_chain_out <= 1'b0;
			iob_connect <= 1'b0;
			iob_data_to_cpu <= 1'b0;
			iob_data_oe <= 1'b0;
			held_q <= 16'h0000;
		end else begin
			case (ak_q)
				ccp_pkg::AK_IDLE: begin
					if (s_chain && match) begin
						// code may move until here, then frozen
						held_code_q <= prio(en_lam);
						iob_data_o <= {CRATE_CODE, prio(en_lam)};
						iob_data_oe <= 1'b1;
						iob_connect <= 1'b1;
						iob_data_to_cpu <= 1'b1;
						ak_q <= ccp_pkg::AK_HOLD;
					end else if (s_chain) begin
						search_chain_out <= 1'b1;
						ak_q <= ccp_pkg::AK_PASS;
					end
				end
				ccp_pkg::AK_PASS: begin
					if (!s_chain) begin
						search_chain_out <= 1'b0;
						ak_q <= ccp_pkg::AK_IDLE;
					end
				end
				ccp_pkg::AK_HOLD: begin
					held_q <= onehot(held_code_q);
					if (!s_chain) begin
						iob_connect <= 1'b0;
						iob_data_to_cpu <= 1'b0;
						iob_data_oe <= 1'b0;
						ak_q <= ccp_pkg::AK_MASK;
					end
				end
				default: begin
					held_q <= 16'h0000;
					ak_q <= ccp_pkg::AK_IDLE;
				end
			endcase
		end
	end

	// mask survives master clear; auto-clear beats a same-cycle write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mask_q <= ccp_pkg::MASK_RST;
		else begin
			if (wr_fire && paddr == ccp_pkg::A_MASK)
				mask_q <= pwdata[15:0];
			if (ak_q == ccp_pkg::AK_MASK)
				mask_q <= (wr_fire && paddr == ccp_pkg::A_MASK ?
					pwdata[15:0] : mask_q) & ~held_q;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule // ccp_bridge
`default_nettype wire

/* File: hdl/ccp_pkg.sv */
// Purpose: constants and types for the crate controller bridge
// Assumes: apb data 32 bits, registers in low 16 bits
// Notes: offsets are byte addresses
package ccp_pkg;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_DATA = 8'h08;
	localparam logic [7:0] A_CMD = 8'h0c;
	localparam logic [7:0] A_XCMD = 8'h10;
	localparam logic [7:0] A_XDAT = 8'h14;
	localparam logic [7:0] A_MASK = 8'h18;
	localparam logic [7:0] A_LAM = 8'h1c;
	// command register fields
	localparam int F_LO = 0;
	localparam int F8_BIT = 3;
	localparam int F16_BIT = 4;
	localparam int A_LO = 5;
	localparam int N_LO = 9;
	// control register fields
	localparam int CT_LVL_LO = 0;
	localparam int CT_CDM = 3;
	localparam int CT_INH = 4;
	localparam int CT_GZ = 8;
	localparam int CT_GC = 9;
	localparam logic [15:0] CT_KEEP = 16'h001f;
	// status register fields
	localparam int ST_I = 0;
	localparam int ST_Q = 1;
	localparam int ST_X = 2;
	localparam int ST_DEM = 3;
	localparam int ST_C = 12;
	localparam int ST_Z = 13;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] MASK_RST = 16'h0000;
	localparam logic [15:0] ZERO16 = 16'h0000;
	// dataway phase timing
	localparam int CLK_NS = 100;
	localparam int T_PHASE_NS = 200;
	localparam int PHASE_CYC = (T_PHASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SY_W = 42;
	typedef enum logic [2:0] {
		DW_IDLE = 3'b000,
		DW_SETUP = 3'b001,
		DW_S1 = 3'b010,
		DW_GAP = 3'b011,
		DW_S2 = 3'b100,
		DW_DONE = 3'b101
	} ccp_dw_t;
	typedef enum logic [1:0] {
		AK_IDLE = 2'b00,
		AK_PASS = 2'b01,
		AK_HOLD = 2'b10,
		AK_MASK = 2'b11
	} ccp_ak_t;
	typedef enum logic [1:0] {
		CL_READ = 2'b00,
		CL_WRITE = 2'b01,
		CL_CTRL = 2'b10
	} ccp_cls_t;
	typedef enum logic [1:0] {
		KD_ADDR = 2'b00,
		KD_Z = 2'b01,
		KD_C = 2'b10
	} ccp_kind_t;
endpackage

/* File: tb/ccp_bridge_asserts.sv */
// Purpose: port-level checks for the crate bridge
// Assumes: one pclk domain, presetn async active low
// Notes: bound into every ccp_bridge instance
`timescale 1ns/100ps
`default_nettype none
module ccp_bridge_asserts #(
	parameter logic [3:0] CRATE_CODE = 4'h1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic search_chain_in,
	input wire logic search_chain_out,
	input wire logic iob_connect,
	input wire logic iob_data_to_cpu,
	input wire logic [7:0] iob_data_o,
	input wire logic iob_data_oe,
	input wire logic [3:0] iob_irq_o,
	input wire logic [3:0] iob_irq_oe,
	input wire logic [4:0] dw_f,
	input wire logic dw_w_oe,
	input wire logic dw_busy,
	input wire logic dw_s1,
	input wire logic dw_s2
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_irq_active_only: assert property ((iob_irq_oe != 4'h0) |-> ((iob_irq_o & iob_irq_oe) == iob_irq_oe))
		else $error("request line driven inactive");
	a_irq_one_line: assert property ($onehot0(iob_irq_oe))
		else $error("more than one request line driven");
	a_write_class_oe: assert property (dw_w_oe |-> dw_busy && dw_f[4] && !dw_f[3])
		else $error("write lines driven outside a write cycle");
	a_s1_in_cycle: assert property (dw_s1 |-> dw_busy && !dw_s2)
		else $error("strobe one outside a cycle");
	a_s2_after_s1: assert property ($rose(dw_s2) |-> $past(dw_s1, 2) && !dw_s1)
		else $error("strobe two not one gap after strobe one");
	a_connect_blocks: assert property (iob_connect |-> !search_chain_out)
		else $error("chain passed on while acknowledging");
	a_vector_static: assert property (iob_data_to_cpu && $past(iob_data_to_cpu) |-> $stable(iob_data_o))
		else $error("vector moved while presented");
	a_vector_crate: assert property (iob_data_oe |-> iob_data_o[7:4] == CRATE_CODE)
		else $error("vector crate code wrong");
	a_chain_dies: assert property (!search_chain_in [*8] |-> !search_chain_out)
		else $error("chain out without chain in");
	c_write_strobe: cover property (dw_w_oe && dw_s1);
	c_ident: cover property (iob_connect && iob_data_to_cpu);
	c_refused: cover property (pready && pslverr);
endmodule // ccp_bridge_asserts
bind ccp_bridge ccp_bridge_asserts #(.CRATE_CODE(CRATE_CODE)) chk_u (.pclk, .presetn, .pready,
	.pslverr, .search_chain_in, .search_chain_out, .iob_connect, .iob_data_to_cpu, .iob_data_o,
	.iob_data_oe, .iob_irq_o, .iob_irq_oe, .dw_f, .dw_w_oe, .dw_busy, .dw_s1, .dw_s2);
`default_nettype wire

/* File: tb/ccp_dway_model.sv */
// Purpose: behavioural crate module on the dataway
// Assumes: answers at once while the cycle runs
// Notes: idle lines toggle so a late latch reads garbage
`timescale 1ns/100ps
`default_nettype none
module ccp_dway_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic dw_busy,
	input wire logic [4:0] dw_n,
	input wire logic [3:0] dw_a,
	input wire logic dw_s1,
	input wire logic [15:0] dw_w,
	input wire logic dw_w_oe,
	input wire logic dw_z,
	input wire logic dw_c,
	input wire logic dw_i,
	output logic [15:0] dw_r,
	output logic dw_q,
	output logic dw_x,
	output logic dw_z_sense,
	output logic dw_c_sense,
	output logic dw_i_sense,
	output logic [15:0] last_w
);
	logic tg_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tg_q <= 1'b0;
			last_w <= 16'h0000;
		end else begin
			tg_q <= ~tg_q;
			if (dw_s1 && dw_w_oe) begin
				last_w <= dw_w;
			end
		end
	end
	assign dw_r = dw_busy ? {dw_n, dw_a, 7'h35} : ({16{tg_q}} ^ 16'h5a5a);
	assign dw_q = dw_busy ? dw_a[0] : tg_q;
	assign dw_x = dw_busy ? 1'b1 : ~tg_q;
	assign dw_z_sense = dw_z;
	assign dw_c_sense = dw_c;
	assign dw_i_sense = dw_i;
endmodule // ccp_dway_model
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: self-checking bench for the crate bridge
// Assumes: apb master, one far-side dataway model
// Notes: random values from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam logic [3:0] CC = 4'ha; // arbitrary crate code
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, master_clear, search_chain_in;
	logic [7:0] paddr, iob_data_o;
	logic [31:0] pwdata, prdata;
	logic [2:0] iob_level;
	logic search_chain_out, iob_connect, iob_data_to_cpu, iob_data_oe, dw_w_oe, dw_q, dw_x;
	logic [3:0] iob_irq_o, iob_irq_oe, dw_a;
	logic [4:0] dw_n, dw_f;
	logic [15:0] dw_w, dw_r, graded_lam, last_w;
	logic dw_busy, dw_s1, dw_s2, dw_z, dw_c, dw_i, dw_z_sense, dw_c_sense, dw_i_sense, z_seen;
	int fail_count, checks, cyc;
	ccp_bridge #(.CRATE_CODE(CC)) dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .master_clear, .search_chain_in, .iob_level,
		.search_chain_out, .iob_connect, .iob_data_to_cpu, .iob_data_o, .iob_data_oe, .iob_irq_o,
		.iob_irq_oe, .dw_n, .dw_a, .dw_f, .dw_w, .dw_w_oe, .dw_r, .dw_q, .dw_x, .dw_busy, .dw_s1,
		.dw_s2, .dw_z, .dw_c, .dw_i, .dw_z_sense, .dw_c_sense, .dw_i_sense, .graded_lam);
	ccp_dway_model dw_u (.pclk, .presetn, .dw_busy, .dw_n, .dw_a, .dw_s1, .dw_w, .dw_w_oe,
		.dw_z, .dw_c, .dw_i, .dw_r, .dw_q, .dw_x, .dw_z_sense, .dw_c_sense, .dw_i_sense, .last_w);
	always #50 pclk = ~pclk;
	// ceiling well above the several hundred cycles the tests need
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (dw_z === 1'b1) z_seen <= 1'b1;
		if (cyc > 20000) begin
			fail_count++;
			end_sim();
		end
	end
	task end_sim;
		if (fail_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [3:0] hi(input logic [15:0] x);
		hi = 4'h0;
		for (int j = 0; j < 16; j++)
			if (x[j]) hi = j[3:0];
	endfunction
	task apb(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [31:0] r,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// read at the rising edge itself, before the slave moves on
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task rc(input string nm, input logic [7:0] a, input logic [31:0] ex);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 16'h0000, r, e);
		chk(nm, r, ex);
	endtask
	task wait_dw;
		int n;
		logic s;
		s = 1'b0;
		for (n = 0; n < 80; n++) begin
			@(negedge pclk);
			if (dw_busy === 1'b1) s = 1'b1;
			else if (s) break;
		end
		chk("dataway cycle done", {31'h0, s && n < 80}, 32'h1);
	endtask
	initial begin
		logic [31:0] v, r;
		logic e;
		logic [15:0] lam, mv, d, km;
		logic [13:0] cmd;
		logic [7:0] ad;
		logic [4:0] n5;
		logic [3:0] a4;
		int i, k;
		pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0; master_clear = 1'b0; search_chain_in = 1'b0;
		iob_level = 3'h0; graded_lam = 16'h0000; fail_count = 0; checks = 0; cyc = 0; z_seen = 1'b0;
		v = $urandom(32'h2ac74dbc);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rc("mask reset", ccp_pkg::A_MASK, {16'h0, ccp_pkg::MASK_RST});
		for (i = 0; i < 12; i++) begin
			v = $urandom;
			ad = (i % 4 == 0) ? ccp_pkg::A_CTRL : (i % 4 == 1) ? ccp_pkg::A_DATA :
				(i % 4 == 2) ? ccp_pkg::A_CMD : ccp_pkg::A_MASK;
			km = (i % 4 == 0) ? ccp_pkg::CT_KEEP : (i % 4 == 2) ? 16'h3fff : 16'hffff;
			wr(ad, v[15:0] & km);
			rc("readback", ad, {16'h0, v[15:0] & km});
		end
		apb(1'b1, 8'h20, 16'hffff, r, e);
		chk("unmapped refused", {31'h0, e}, 32'h1);
		apb(1'b0, 8'h06, 16'h0000, r, e);
		chk("unaligned refused", {31'h0, e}, 32'h1);
		for (i = 0; i < 4; i++) begin
			v = $urandom;
			n5 = (i < 2) ? {5{i[0]}} : v[4:0];
			a4 = (i < 2) ? {4{i[0]}} : v[8:5];
			cmd = {n5, a4, 2'b00, v[11:9]};
			wr(ccp_pkg::A_CMD, {2'b00, cmd});
			rc("read data", ccp_pkg::A_XCMD, {16'h0, n5, a4, 7'h35});
			apb(1'b0, ccp_pkg::A_STAT, 16'h0000, r, e);
			chk("q and x", {30'h0, r[ccp_pkg::ST_X], r[ccp_pkg::ST_Q]}, {30'h0, 1'b1, a4[0]});
		end
		v = $urandom;
		cmd = {v[13:5], 2'b10, v[2:0]};
		wr(ccp_pkg::A_CMD, {2'b00, cmd});
		for (i = 0; i < 3; i++) begin
			d = (i == 0) ? 16'hffff : 16'($urandom);
			if (i < 2) wr(ccp_pkg::A_XDAT, d);
			else begin
				wr(ccp_pkg::A_DATA, d);
				wr(ccp_pkg::A_XCMD, {2'b00, cmd});
			end
			chk("write lines", {16'h0, last_w}, {16'h0, d});
		end
		v = $urandom;
		wr(ccp_pkg::A_XCMD, {2'b00, v[13:4], 1'b1, v[2:0]});
		rc("data kept", ccp_pkg::A_DATA, {16'h0, d});
		for (i = 0; i < 2; i++) begin
			wr(ccp_pkg::A_DATA, 16'h1234);
			wr(ccp_pkg::A_CMD, 16'h0abc);
			wr(ccp_pkg::A_CTRL, (i == 0) ? 16'h0200 : 16'h0100);
			wait_dw();
			rc("data cleared", ccp_pkg::A_DATA, 32'h0);
			rc("cmd cleared", ccp_pkg::A_CMD, 32'h0);
		end
		mv = 16'($urandom);
		wr(ccp_pkg::A_MASK, mv);
		wr(ccp_pkg::A_CTRL, 16'h000d);
		z_seen = 1'b0;
		@(posedge pclk) master_clear <= 1'b1;
		repeat (6) @(posedge pclk);
		master_clear <= 1'b0;
		wait_dw();
		chk("z after clear", {31'h0, z_seen}, 32'h1);
		rc("ctrl cleared", ccp_pkg::A_CTRL, 32'h10);
		rc("mask kept", ccp_pkg::A_MASK, {16'h0, mv});
		apb(1'b0, ccp_pkg::A_STAT, 16'h0000, r, e);
		chk("z status", {29'h0, r[ccp_pkg::ST_Z], r[ccp_pkg::ST_C], r[ccp_pkg::ST_I]},
			32'h7);
		for (k = 0; k < 4; k++) begin
			v = $urandom;
			lam = (k == 0) ? 16'h8001 : (v[15:0] | 16'h0001);
			mv = v[31:16] | 16'h0001;
			graded_lam <= lam;
			wr(ccp_pkg::A_MASK, 16'h0000);
			wr(ccp_pkg::A_CTRL, 16'h0008 | 16'(k));
			repeat (8) @(posedge pclk);
			chk("masked demand", {28'h0, iob_irq_oe}, 32'h0);
			rc("lam status", ccp_pkg::A_LAM, {16'h0, lam});
			wr(ccp_pkg::A_MASK, mv);
			wr(ccp_pkg::A_CTRL, 16'(k));
			repeat (8) @(posedge pclk);
			chk("crate mask off", {28'h0, iob_irq_oe}, 32'h0);
			wr(ccp_pkg::A_CTRL, 16'h0008 | 16'(k));
			repeat (8) @(posedge pclk);
			chk("request line", {28'h0, iob_irq_oe}, 32'h1 << k);
			iob_level <= 3'(k) ^ 3'h1;
			search_chain_in <= 1'b1;
			for (i = 0; i < 20 && search_chain_out !== 1'b1; i++) @(negedge pclk);
			chk("chain passed", {30'h0, search_chain_out, iob_connect}, 32'h2);
			@(posedge pclk) search_chain_in <= 1'b0;
			repeat (10) @(posedge pclk);
			iob_level <= 3'(k);
			search_chain_in <= 1'b1;
			for (i = 0; i < 20 && iob_data_to_cpu !== 1'b1; i++) @(negedge pclk);
			chk("acknowledge", {30'h0, search_chain_out, iob_connect}, 32'h1);
			chk("vector", {24'h0, iob_data_o}, {24'h0, CC, hi(lam & mv)});
			@(posedge pclk) search_chain_in <= 1'b0;
			repeat (10) @(posedge pclk);
			rc("automask", ccp_pkg::A_MASK, {16'h0, mv & ~(16'h1 << hi(lam & mv))});
		end
		end_sim();
	end
endmodule // testbench
`default_nettype wire
